/* File: hw/cmpi_pkg.sv */
package cmpi_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CMPI_OFF_CORE_IRQ   = 8'h00;
   localparam logic [7:0] CMPI_OFF_FLAGS_TWO  = 8'h04;
   localparam logic [7:0] CMPI_OFF_EN_TWO     = 8'h08;
   localparam logic [7:0] CMPI_OFF_PRIO_TWO   = 8'h0c;
   localparam logic [7:0] CMPI_OFF_CMP_CTRL   = 8'h10;
   localparam logic [7:0] CMPI_OFF_LADDER     = 8'h14;
   localparam logic [7:0] CMPI_OFF_PORT_PINS  = 8'h18;
   localparam logic [7:0] CMPI_OFF_PORT_LATCH = 8'h1c;
   localparam logic [7:0] CMPI_OFF_PORT_DIR   = 8'h20;
   localparam logic [7:0] CMPI_OFF_CONV_ONE   = 8'h24;
   localparam logic [7:0] CMPI_OFF_CTRL_EXT   = 8'h28;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CMPI_BIT_SECOND_RESULT   = 7;
   localparam int CMPI_BIT_FIRST_RESULT    = 6;
   localparam int CMPI_BIT_SECOND_INVERT   = 5;
   localparam int CMPI_BIT_FIRST_INVERT    = 4;
   localparam int CMPI_BIT_INPUT_SWITCH    = 3;
   localparam int CMPI_BIT_CHANGE_FLAG     = 6;
   localparam int CMPI_BIT_CHANGE_ENABLE   = 6;
   localparam int CMPI_BIT_CHANGE_PRIO     = 6;
   localparam int CMPI_BIT_GLOBAL_EN       = 7;
   localparam int CMPI_BIT_PERIPH_EN       = 6;
   localparam int CMPI_BIT_RANGE_SELECT    = 5;
   localparam int CMPI_BIT_SOURCE_SELECT   = 4;
   localparam int CMPI_BIT_FIRST_PIN       = 1;
   localparam int CMPI_BIT_SECOND_PIN      = 2;
   localparam int CMPI_BIT_PIN_ROUTE_EN    = 0;
   localparam int CMPI_BIT_SLEEP           = 1;

   // ------------------------------------------------------------
   // masks and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CMPI_CMP_CTRL_WMASK  = 8'h3f;
   localparam logic [7:0] CMPI_FLAGS_TWO_MASK  = 8'hcb;
   localparam logic [7:0] CMPI_PORT_MASK       = 8'hfe;
   localparam logic [7:0] CMPI_CONV_ONE_MASK   = 8'h0f;
   localparam logic [7:0] CMPI_CTRL_EXT_MASK   = 8'h03;
   localparam logic [7:0] CMPI_CMP_CTRL_RESET  = 8'h07;
   localparam logic [7:0] CMPI_PORT_DIR_RESET  = 8'hfe;
   localparam logic [7:0] CMPI_ZERO8           = 8'h00;
   localparam logic [2:0] CMPI_MODE_OFF        = 3'h7;
   localparam logic [2:0] CMPI_MODE_MUX_REF    = 3'h6;
   localparam logic [3:0] CMPI_CONV_ONE_RESET  = 4'h0;
   localparam logic [3:0] CMPI_ALL_DIGITAL     = 4'hf;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       hsel;
      logic [7:0] haddr;
      logic [1:0] htrans;
      logic       hwrite;
      logic [2:0] hsize;
      logic       hready;
   } cmpi_ahb_addr_t;

   typedef struct packed {
      logic       ladder_range_select;
      logic       ladder_source_select;
      logic [3:0] ladder_level_value;
      logic [2:0] comparator_mode_field;
      logic       input_switch_select;
      logic       ref_to_plus_inputs;
   } cmpi_analog_ctrl_t;

endpackage : cmpi_pkg

/* File: hw/cmpi_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpi_sync2
   import cmpi_pkg::*;
(
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // level
   input  wire logic async_in,
   output var  logic sync_out
);

   typedef struct packed {
      logic first_stage;
      logic second_stage;
   } cmpi_sync_state_t;

   cmpi_sync_state_t state_reg;
   cmpi_sync_state_t state_next;

   always_comb
   begin
      state_next              = state_reg;
      state_next.first_stage  = async_in;
      state_next.second_stage = state_reg.first_stage;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign sync_out = state_reg.second_stage;

endmodule : cmpi_sync2
`default_nettype wire

/* File: hw/cmpi_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpi_pin_mux
   import cmpi_pkg::*;
(
   // selection
   input  wire logic route_en,
   input  wire logic compare_result,
   input  wire logic latch_bit,
   input  wire logic direction_bit,
   // pin drive
   output var  logic pin_out,
   output var  logic pin_oe
);

   // ------------------------------------------------------------
   // unsynchronised result onto the pin
   // ------------------------------------------------------------
   always_comb
   begin
      pin_out = route_en ? compare_result : latch_bit;
      pin_oe  = !direction_bit;
   end

endmodule : cmpi_pin_mux
`default_nettype wire

/* File: hw/cmpi_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpi_top
   import cmpi_pkg::*;
(
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [7:0]        haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic [31:0]       hrdata,
   output var  logic              hreadyout,
   output var  logic              hresp,
   // analog comparator cores
   input  wire logic              first_raw_high,
   input  wire logic              second_raw_high,
   output var  cmpi_analog_ctrl_t analog_ctrl,
   // port f pins
   input  wire logic [7:0]        port_f_in,
   output var  logic              first_result_pin_out,
   output var  logic              first_result_pin_oe,
   output var  logic              second_result_pin_out,
   output var  logic              second_result_pin_oe,
   // interrupt and sleep
   output var  logic              compare_irq,
   output var  logic              wake_request,
   output var  logic              sleeping
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]        core_interrupt_control;
      logic [7:0]        peripheral_flags_two;
      logic [7:0]        peripheral_enables_two;
      logic [7:0]        peripheral_priority_two;
      logic [5:0]        comparator_control;
      logic [7:0]        reference_ladder_control;
      logic [7:0]        port_f_latch;
      logic [7:0]        port_f_direction;
      logic [3:0]        pin_analog_config;
      logic [1:0]        ctrl_ext;
      logic [1:0]        latched_results;
      logic              dp_valid;
      logic              dp_write;
      logic [7:0]        dp_addr;
      logic [31:0]       rdata;
      logic              irq;
      logic              wake;
      logic              out1;
      logic              oe1;
      logic              out2;
      logic              oe2;
      cmpi_analog_ctrl_t actl;
   } cmpi_state_t;

   cmpi_state_t state_reg;
   cmpi_state_t state_next;

   logic       first_sync;
   logic       second_sync;
   logic [1:0] results_now;
   logic       pin1_out;
   logic       pin1_oe;
   logic       pin2_out;
   logic       pin2_oe;

   // ------------------------------------------------------------
   // synchronisers and pin muxes
   // ------------------------------------------------------------
   cmpi_sync2 u_sync_first (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (first_raw_high),
      .sync_out (first_sync)
   );

   cmpi_sync2 u_sync_second (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (second_raw_high),
      .sync_out (second_sync)
   );

   // invert after sync; mode off forces both low
   always_comb
   begin
      results_now = '0;
      if (state_reg.comparator_control[2:0] != CMPI_MODE_OFF)
      begin
         results_now[1] = second_sync ^ state_reg.comparator_control[CMPI_BIT_SECOND_INVERT];
         results_now[0] = first_sync ^ state_reg.comparator_control[CMPI_BIT_FIRST_INVERT];
      end
   end

   cmpi_pin_mux u_pin_first (
      .route_en       (state_reg.ctrl_ext[CMPI_BIT_PIN_ROUTE_EN]),
      .compare_result (first_raw_high ^ state_reg.comparator_control[CMPI_BIT_FIRST_INVERT]),
      .latch_bit      (state_reg.port_f_latch[CMPI_BIT_FIRST_PIN]),
      .direction_bit  (state_reg.port_f_direction[CMPI_BIT_FIRST_PIN]),
      .pin_out        (pin1_out),
      .pin_oe         (pin1_oe)
   );

   cmpi_pin_mux u_pin_second (
      .route_en       (state_reg.ctrl_ext[CMPI_BIT_PIN_ROUTE_EN]),
      .compare_result (second_raw_high ^ state_reg.comparator_control[CMPI_BIT_SECOND_INVERT]),
      .latch_bit      (state_reg.port_f_latch[CMPI_BIT_SECOND_PIN]),
      .direction_bit  (state_reg.port_f_direction[CMPI_BIT_SECOND_PIN]),
      .pin_out        (pin2_out),
      .pin_oe         (pin2_oe)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic        take;
   logic        cmp_access;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic [7:0]  port_read;
   logic        mismatch;
   logic        set_ev;

   always_comb
   begin
      state_next = state_reg;
      wbyte      = hwdata[7:0];
      rbyte      = CMPI_ZERO8;
      port_read  = CMPI_ZERO8;
      take       = hsel && hready && htrans[1];
      // one bus access to the control register in data phase
      cmp_access = state_reg.dp_valid && (state_reg.dp_addr == CMPI_OFF_CMP_CTRL);
      mismatch   = results_now != state_reg.latched_results;
      // a change landing on the access cycle is absorbed by the latch
      set_ev     = mismatch && !cmp_access;

      // address phase capture
      state_next.dp_valid = take;
      state_next.dp_write = hwrite;
      state_next.dp_addr  = haddr;
      if (take && !hwrite)
      begin
         case (haddr)
            CMPI_OFF_CORE_IRQ:   rbyte = state_reg.core_interrupt_control;
            CMPI_OFF_FLAGS_TWO:  rbyte = state_reg.peripheral_flags_two;
            CMPI_OFF_EN_TWO:     rbyte = state_reg.peripheral_enables_two;
            CMPI_OFF_PRIO_TWO:   rbyte = state_reg.peripheral_priority_two;
            CMPI_OFF_CMP_CTRL:   rbyte = {results_now, state_reg.comparator_control};
            CMPI_OFF_LADDER:     rbyte = state_reg.reference_ladder_control;
            CMPI_OFF_PORT_PINS:
            begin
               port_read = port_f_in & CMPI_PORT_MASK;
               // pins 3..6 analog unless config says all digital
               if (state_reg.pin_analog_config != CMPI_ALL_DIGITAL)
                  port_read[6:3] = 4'h0;
               rbyte = port_read;
            end
            CMPI_OFF_PORT_LATCH: rbyte = state_reg.port_f_latch;
            CMPI_OFF_PORT_DIR:   rbyte = state_reg.port_f_direction;
            CMPI_OFF_CONV_ONE:   rbyte = {4'h0, state_reg.pin_analog_config};
            CMPI_OFF_CTRL_EXT:   rbyte = {6'h00, state_reg.ctrl_ext};
            default:             rbyte = CMPI_ZERO8;
         endcase
      end
      state_next.rdata = {24'h000000, rbyte};

      // data phase writes
      if (state_reg.dp_valid && state_reg.dp_write)
      begin
         case (state_reg.dp_addr)
            CMPI_OFF_CORE_IRQ:   state_next.core_interrupt_control = wbyte;
            CMPI_OFF_FLAGS_TWO:  state_next.peripheral_flags_two = wbyte & CMPI_FLAGS_TWO_MASK;
            CMPI_OFF_EN_TWO:     state_next.peripheral_enables_two = wbyte & CMPI_FLAGS_TWO_MASK;
            CMPI_OFF_PRIO_TWO:   state_next.peripheral_priority_two = wbyte & CMPI_FLAGS_TWO_MASK;
            CMPI_OFF_CMP_CTRL:
               state_next.comparator_control = wbyte[5:0] & CMPI_CMP_CTRL_WMASK[5:0];
            CMPI_OFF_LADDER:     state_next.reference_ladder_control = wbyte;
            CMPI_OFF_PORT_LATCH: state_next.port_f_latch = wbyte & CMPI_PORT_MASK;
            CMPI_OFF_PORT_DIR:   state_next.port_f_direction = wbyte & CMPI_PORT_MASK;
            CMPI_OFF_CONV_ONE:   state_next.pin_analog_config = wbyte[3:0];
            CMPI_OFF_CTRL_EXT:   state_next.ctrl_ext = wbyte[1:0] & CMPI_CTRL_EXT_MASK[1:0];
            default:             state_next.ctrl_ext = state_reg.ctrl_ext;
         endcase
      end

      // any control access latches reference results
      if (cmp_access)
         state_next.latched_results = results_now;

      // hardware set wins over software clear; enables not consulted
      if (set_ev)
         state_next.peripheral_flags_two[CMPI_BIT_CHANGE_FLAG] = 1'b1;

      // request gating
      state_next.irq = state_reg.peripheral_flags_two[CMPI_BIT_CHANGE_FLAG]
                     && state_reg.peripheral_enables_two[CMPI_BIT_CHANGE_ENABLE]
                     && state_reg.core_interrupt_control[CMPI_BIT_PERIPH_EN]
                     && state_reg.core_interrupt_control[CMPI_BIT_GLOBAL_EN];
      // wake needs only flag and enable, valid while sleeping
      state_next.wake = state_reg.ctrl_ext[CMPI_BIT_SLEEP]
                     && state_reg.peripheral_flags_two[CMPI_BIT_CHANGE_FLAG]
                     && state_reg.peripheral_enables_two[CMPI_BIT_CHANGE_ENABLE];
      // waking clears sleep only; control register kept
      if (state_reg.wake)
         state_next.ctrl_ext[CMPI_BIT_SLEEP] = 1'b0;

      state_next.out1 = pin1_out;
      state_next.oe1  = pin1_oe;
      state_next.out2 = pin2_out;
      state_next.oe2  = pin2_oe;

      // analog side controls
      state_next.actl.ladder_range_select   =
         state_reg.reference_ladder_control[CMPI_BIT_RANGE_SELECT];
      state_next.actl.ladder_source_select  =
         state_reg.reference_ladder_control[CMPI_BIT_SOURCE_SELECT];
      state_next.actl.ladder_level_value    = state_reg.reference_ladder_control[3:0];
      state_next.actl.comparator_mode_field = state_reg.comparator_control[2:0];
      state_next.actl.input_switch_select   =
         state_reg.comparator_control[CMPI_BIT_INPUT_SWITCH];
      state_next.actl.ref_to_plus_inputs    =
         state_reg.comparator_control[2:0] == CMPI_MODE_MUX_REF;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg                    <= '0;
         state_reg.comparator_control <= CMPI_CMP_CTRL_RESET[5:0];
         state_reg.port_f_direction   <= CMPI_PORT_DIR_RESET;
         state_reg.pin_analog_config  <= CMPI_CONV_ONE_RESET;
         state_reg.oe1                <= 1'b0;
         state_reg.oe2                <= 1'b0;
         state_reg.actl.comparator_mode_field <= CMPI_MODE_OFF;
      end
      else
         state_reg <= state_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign hrdata                = state_reg.rdata;
   assign hreadyout             = 1'b1;
   assign hresp                 = 1'b0;
   assign analog_ctrl           = state_reg.actl;
   assign first_result_pin_out  = state_reg.out1;
   assign first_result_pin_oe   = state_reg.oe1;
   assign second_result_pin_out = state_reg.out2;
   assign second_result_pin_oe  = state_reg.oe2;
   assign compare_irq           = state_reg.irq;
   assign wake_request          = state_reg.wake;
   assign sleeping              = state_reg.ctrl_ext[CMPI_BIT_SLEEP];

endmodule : cmpi_top
`default_nettype wire

/* File: tb/cmpi_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpi_top_sva
   import cmpi_pkg::*;
(
   // clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // bus
   input wire logic              hsel,
   input wire logic [7:0]        haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   // analog and sleep
   input wire cmpi_analog_ctrl_t analog_ctrl,
   input wire logic              wake_request,
   input wire logic              sleeping
);
   // ------------------------------------------------------------
   // data-phase tracking
   // ------------------------------------------------------------
   logic       dp_v;
   logic       dp_w;
   logic [7:0] dp_a;
   logic [5:0] lad_q;
   logic [2:0] mode_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_v   <= 1'b0;
         dp_w   <= 1'b0;
         dp_a   <= 8'h00;
         lad_q  <= 6'h00;
         mode_q <= 3'h7;
      end
      else
      begin
         dp_v <= hsel && hready && htrans[1];
         dp_w <= hwrite;
         dp_a <= haddr;
         if (dp_v && dp_w && dp_a == CMPI_OFF_LADDER)
            lad_q <= hwdata[5:0];
         if (dp_v && dp_w && dp_a == CMPI_OFF_CMP_CTRL)
            mode_q <= hwdata[2:0];
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_idle_zero: assert property ((!dp_v || dp_w) |-> hrdata == 32'h0)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (dp_v && !dp_w && dp_a > CMPI_OFF_CTRL_EXT |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_off_results: assert property (dp_v && !dp_w && dp_a == CMPI_OFF_CMP_CTRL
      && analog_ctrl.comparator_mode_field == CMPI_MODE_OFF
      && $stable(analog_ctrl.comparator_mode_field) |-> hrdata[7:6] == 2'b00)
      else $error("results not zero in off mode");
   a_reset_mode: assert property ($rose(hresetn) |-> analog_ctrl.comparator_mode_field == 3'h7)
      else $error("mode not off after reset");
   a_mode_write: assert property (dp_v && dp_w && dp_a == CMPI_OFF_CMP_CTRL
      |-> ##[1:2] analog_ctrl.comparator_mode_field == mode_q)
      else $error("mode field not applied");
   a_ladder_write: assert property (dp_v && dp_w && dp_a == CMPI_OFF_LADDER
      |-> ##[1:2] {analog_ctrl.ladder_range_select, analog_ctrl.ladder_source_select,
      analog_ctrl.ladder_level_value} == lad_q)
      else $error("ladder control not applied");
   a_ref_mode: assert property (analog_ctrl.ref_to_plus_inputs
      == (analog_ctrl.comparator_mode_field == 3'h6))
      else $error("reference routing wrong for mode");
   a_wake_sleep: assert property (wake_request |-> $past(sleeping))
      else $error("wake request while not sleeping");
endmodule : cmpi_top_sva
bind cmpi_top cmpi_top_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .analog_ctrl, .wake_request, .sleeping);
`default_nettype wire

/* File: tb/cmpi_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmpi_analog_model
   import cmpi_pkg::*;
(
   // control from the block
   input  wire cmpi_analog_ctrl_t analog_ctrl,
   // pin levels in millivolts
   input  wire logic [11:0]       first_plus_mv,
   input  wire logic [11:0]       first_minus_mv,
   input  wire logic [11:0]       second_plus_mv,
   input  wire logic [11:0]       second_minus_mv,
   // raw results
   output wire logic              first_raw_high,
   output wire logic              second_raw_high
);
   int   src;
   int   ref_mv;
   int   p1;
   int   p2;
   logic on;
   always_comb
   begin
      src = analog_ctrl.ladder_source_select ? 800 : 1000;
      if (analog_ctrl.ladder_range_select)
         ref_mv = src * int'(analog_ctrl.ladder_level_value) / 24;
      else
         ref_mv = src / 4 + src * int'(analog_ctrl.ladder_level_value) / 32;
      on = analog_ctrl.comparator_mode_field != CMPI_MODE_OFF;
      p1 = analog_ctrl.ref_to_plus_inputs ? ref_mv : int'(first_plus_mv);
      p2 = analog_ctrl.ref_to_plus_inputs ? ref_mv : int'(second_plus_mv);
   end
   // slow asynchronous response, off the clock edge
   assign #3 first_raw_high  = on && (p1 > int'(first_minus_mv));
   assign #3 second_raw_high = on && (p2 > int'(second_minus_mv));
endmodule : cmpi_analog_model
`default_nettype wire

/* File: tb/comparator_output_interrupt_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_output_interrupt_bench
   import cmpi_pkg::*;
;
   logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [7:0]        haddr, port_f_in;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       hwdata, hrdata, rd;
   logic              r1, r2, p1o, p1e, p2o, p2e, compare_irq, wake_request, sleeping;
   logic [11:0]       m1p, m1m, m2p, m2m;
   cmpi_analog_ctrl_t analog_ctrl;
   int                err_total, samples_checked, n;
   logic [7:0]        ra [5] = '{CMPI_OFF_CMP_CTRL, CMPI_OFF_PORT_DIR, CMPI_OFF_CONV_ONE,
                                 CMPI_OFF_LADDER, 8'h2c};
   logic [7:0]        rv [5] = '{8'h07, 8'hfe, 8'h00, 8'h00, 8'h00};

   cmpi_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .first_raw_high(r1),
      .second_raw_high(r2), .analog_ctrl, .port_f_in, .first_result_pin_out(p1o),
      .first_result_pin_oe(p1e), .second_result_pin_out(p2o), .second_result_pin_oe(p2e),
      .compare_irq, .wake_request, .sleeping);
   cmpi_analog_model u_model (.analog_ctrl, .first_plus_mv(m1p), .first_minus_mv(m1m),
      .second_plus_mv(m2p), .second_minus_mv(m2m), .first_raw_high(r1), .second_raw_high(r2));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_ready;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1)
      begin
         err_total++;
         tally_and_finish();
      end
   endtask : wait_ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, {24'h0, e});
   endtask : rdchk

   // ------------------------------------------------------------
   // clock and sequence
   // ------------------------------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, hwrite, haddr, htrans, hwdata, err_total, samples_checked} = '0;
      hsize = 3'h2;
      port_f_in = 8'hff;
      {m1p, m1m, m2p, m2m} = {12'd600, 12'd400, 12'd300, 12'd500};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 5; i++)
         rdchk(ra[i], rv[i]);
      rdchk(CMPI_OFF_PORT_PINS, 8'h86);
      wr(CMPI_OFF_CONV_ONE, 8'h0f);
      rdchk(CMPI_OFF_PORT_PINS, 8'hfe);
      wr(CMPI_OFF_CMP_CTRL, 8'hc2);
      repeat (5) @(posedge hclk);
      rdchk(CMPI_OFF_CMP_CTRL, 8'h42);
      wr(CMPI_OFF_CMP_CTRL, 8'h32);
      repeat (4) @(posedge hclk);
      rdchk(CMPI_OFF_CMP_CTRL, 8'hb2);
      wr(CMPI_OFF_CMP_CTRL, 8'h02);
      repeat (4) @(posedge hclk);
      rdchk(CMPI_OFF_CMP_CTRL, 8'h42);
      wr(CMPI_OFF_FLAGS_TWO, 8'h00);
      rdchk(CMPI_OFF_FLAGS_TWO, 8'h00);
      m2p <= 12'd700;
      repeat (6) @(posedge hclk);
      rdchk(CMPI_OFF_FLAGS_TWO, 8'h40);
      check(compare_irq, 1'b0);
      wr(CMPI_OFF_FLAGS_TWO, 8'h00);
      rdchk(CMPI_OFF_FLAGS_TWO, 8'h40);
      rdchk(CMPI_OFF_CMP_CTRL, 8'hc2);
      wr(CMPI_OFF_FLAGS_TWO, 8'h00);
      rdchk(CMPI_OFF_FLAGS_TWO, 8'h00);
      wr(CMPI_OFF_FLAGS_TWO, 8'h40);
      rdchk(CMPI_OFF_FLAGS_TWO, 8'h40);
      for (int k = 0; k < 8; k++)
      begin
         wr(CMPI_OFF_EN_TWO, {1'b0, k[0], 6'h0});
         wr(CMPI_OFF_CORE_IRQ, {k[2], k[1], 6'h0});
         repeat (3) @(posedge hclk);
         check(compare_irq, k == 7);
      end
      wr(CMPI_OFF_CORE_IRQ, 8'h00);
      wr(CMPI_OFF_FLAGS_TWO, 8'h00);
      wr(CMPI_OFF_CTRL_EXT, 8'h02);
      repeat (2) @(posedge hclk);
      check(sleeping, 1'b1);
      m1p <= 12'd300;
      for (n = 0; n < 20 && wake_request !== 1'b1; n++)
         @(posedge hclk);
      check(wake_request, 1'b1);
      if (n == 20)
         tally_and_finish();
      rdchk(CMPI_OFF_CMP_CTRL, 8'h82);
      wr(CMPI_OFF_CTRL_EXT, 8'h01);
      wr(CMPI_OFF_PORT_DIR, 8'hf8);
      repeat (3) @(posedge hclk);
      check({p1o, p1e, p2o, p2e}, 4'b0111);
      wr(CMPI_OFF_CMP_CTRL, 8'h12);
      repeat (3) @(posedge hclk);
      check({p1o, p2o}, 2'b11);
      wr(CMPI_OFF_PORT_DIR, 8'hfe);
      repeat (3) @(posedge hclk);
      check({p1e, p2e}, 2'b00);
      wr(CMPI_OFF_LADDER, 8'h3a);
      rdchk(CMPI_OFF_LADDER, 8'h3a);
      m2m <= 12'd200;
      wr(CMPI_OFF_CMP_CTRL, 8'h06);
      repeat (6) @(posedge hclk);
      check(analog_ctrl.ref_to_plus_inputs, 1'b1);
      rdchk(CMPI_OFF_CMP_CTRL, 8'h86);
      wr(CMPI_OFF_CMP_CTRL, 8'h07);
      repeat (4) @(posedge hclk);
      rdchk(CMPI_OFF_CMP_CTRL, 8'h07);
      wr(CMPI_OFF_CMP_CTRL, 8'h02);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(CMPI_OFF_CMP_CTRL, 8'h07);
      rdchk(CMPI_OFF_LADDER, 8'h00);
      tally_and_finish();
   end
endmodule : comparator_output_interrupt_bench
`default_nettype wire
